// >>> shared/qlt_regs.vh
// Constants for the four-channel bus transceiver mode control block
// How it works
// - Each channel keeps its own mode state
// - Normal goes Sleep after long low control
// - Valid bus wake moves Sleep to Standby
// - Local wake needs control high beyond go-to-normal
// - Standby holds receive output low until wake request clears
// - Control high in Standby clears wake request
// - Long control high from Sleep/Standby gives Normal
// - Only Normal passes data; receive mirrors bus
// - Transmit low drives bus dominant in Normal
// - Low supply holds pair in power-on reset
// - Remote wake needs long dominant then rising
// - Overtemperature disables both drivers of pair
// - Transmit low too long releases the bus
// - Floating control input reads low; Normal goes Sleep, Standby stays
// - Floating transmit input resolves to low
// - Driver waits for transmit high after Normal entry
// - Receive floats in Sleep/reset; transmitter off
`ifndef QLT_REGS_VH
`define QLT_REGS_VH

// Clock rate
`define QLT_CLK_MHZ         20
// Durations in ns, plain defaults
`define QLT_T_GOTOSLEEP_NS  5000
`define QLT_T_GOTONORM_NS   5000
`define QLT_T_WAKE_DOM_NS   50000
`define QLT_T_TX_TO_NS      20000000
// Least times, rounded up to whole cycles
`define QLT_CYC(ns) (((ns) * `QLT_CLK_MHZ + 999) / 1000)
`define QLT_GOTOSLEEP_CYC   `QLT_CYC(`QLT_T_GOTOSLEEP_NS)
`define QLT_GOTONORM_CYC    `QLT_CYC(`QLT_T_GOTONORM_NS)
`define QLT_WAKE_DOM_CYC    `QLT_CYC(`QLT_T_WAKE_DOM_NS)
`define QLT_TX_TO_CYC       `QLT_CYC(`QLT_T_TX_TO_NS)
// Counter width
`define QLT_CNT_W           20
// Mode encodings
`define QLT_MODE_POR        2'h0
`define QLT_MODE_SLEEP      2'h1
`define QLT_MODE_STBY       2'h2
`define QLT_MODE_NORM       2'h3
// Event word: channel in [3:2], new mode in [1:0]
`define QLT_EVT_W           4

`endif

// >>> design/qlt_buf.v
// Two-entry valid/ready buffer for mode-change events
`timescale 1ns/1ns
module qlt_buf #(
    parameter W = 4
) (
    input  wire         clk,       // Clock
    input  wire         rstn,      // Async reset, active low
    input  wire         in_valid,  // Word offered
    output wire         in_ready,  // Room for a word
    input  wire [W-1:0] in_data,   // Word in
    output wire         out_valid, // Word available
    input  wire         out_ready, // Receiver takes word
    output wire [W-1:0] out_data   // Word out, from flops
);

    reg [W-1:0] mem_ff [0:1];
    reg         rd_ptr_ff;
    reg         wr_ptr_ff;
    reg [1:0]   cnt_ff;
    wire        push;
    wire        pop;

    // Honest full and empty
    assign in_ready  = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage, pointers and fill count
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ff[0] <= {W{1'b0}};
            mem_ff[1] <= {W{1'b0}};
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff         <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end

endmodule // qlt_buf

// >>> design/qlt_top.v
// Four-channel transceiver mode control, drivers and wake logic
`timescale 1ns/1ns
`include "qlt_regs.vh"
module qlt_top #(
    parameter GOTOSLEEP_CYC = `QLT_GOTOSLEEP_CYC, // Go-to-sleep filter, cycles
    parameter GOTONORM_CYC  = `QLT_GOTONORM_CYC,  // Go-to-normal filter, cycles
    parameter WAKE_DOM_CYC  = `QLT_WAKE_DOM_CYC,  // Dominant wake time, cycles
    parameter TX_TO_CYC     = `QLT_TX_TO_CYC      // Transmit dominant timeout, cycles
) (
    input  wire                  clk,          // Clock, 20 MHz
    input  wire                  rstn,         // Async reset, active low
    input  wire [3:0]            tx_data_in,   // Transmit data per channel
    input  wire [3:0]            sleep_ctrl_n, // Sleep control per channel, high = normal
    input  wire [3:0]            bus_line_in,  // Bus level per channel, low = dominant
    output wire [3:0]            bus_line_out, // Bus drive value, always dominant
    output wire [3:0]            bus_line_oe,  // Bus pulled dominant while high
    output wire [3:0]            rx_data_out,  // Receive pin value
    output wire [3:0]            rx_data_oe,   // Receive pin driven while high
    input  wire [1:0]            supply_ok,    // Supply above reset threshold, per pair
    input  wire [1:0]            overtemp,     // Overtemperature, per pair
    output wire [1:0]            mode_ch0,     // Channel 0 mode
    output wire [1:0]            mode_ch1,     // Channel 1 mode
    output wire [1:0]            mode_ch2,     // Channel 2 mode
    output wire [1:0]            mode_ch3,     // Channel 3 mode
    output wire                  evt_valid,    // Mode-change event available
    input  wire                  evt_ready,    // Receiver takes event
    output wire [`QLT_EVT_W-1:0] evt_data      // Event: channel, new mode
);

    ////////////////////////////////////////////////////////////////////////////
    // Mode codes and counter width
    localparam [1:0] MODE_POR   = `QLT_MODE_POR;
    localparam [1:0] MODE_SLEEP = `QLT_MODE_SLEEP;
    localparam [1:0] MODE_STBY  = `QLT_MODE_STBY;
    localparam [1:0] MODE_NORM  = `QLT_MODE_NORM;
    localparam       CW         = `QLT_CNT_W;

    // Filter limits as plain integers, then cut to the counter width
    localparam integer  SLEEP_I   = GOTOSLEEP_CYC;
    localparam integer  NORM_I    = GOTONORM_CYC;
    localparam integer  WAKE_I    = WAKE_DOM_CYC;
    localparam integer  TO_I      = TX_TO_CYC;
    localparam [CW-1:0] SLEEP_LIM = SLEEP_I[CW-1:0];
    localparam [CW-1:0] NORM_LIM  = NORM_I[CW-1:0];
    localparam [CW-1:0] WAKE_LIM  = WAKE_I[CW-1:0];
    localparam [CW-1:0] TO_LIM    = TO_I[CW-1:0];

    // Counter saturation value and step
    localparam [CW-1:0] CNT_MAX   = {CW{1'b1}};
    localparam [CW-1:0] CNT_ONE   = {{(CW-1){1'b0}}, 1'b1};

    // Event selection and pending state
    wire [7:0] mode_all;
    wire [3:0] chg;
    reg  [3:0] pend_ff;
    reg  [3:0] nxt_pend;
    reg  [1:0] sel;
    reg        sel_vld;
    wire       buf_ready;
    wire       push;

    // Pin value fixed dominant; the enable does the driving
    assign bus_line_out = 4'h0;

    // Mode outputs, two bits per channel
    assign mode_ch0     = mode_all[1:0];
    assign mode_ch1     = mode_all[3:2];
    assign mode_ch2     = mode_all[5:4];
    assign mode_ch3     = mode_all[7:6];

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel mode machine, filters, driver and receiver
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ch
            // Two-stage synchronisers; transmit and control reset low like the pad pull-downs, bus stages reset high
            reg          tx_m_ff, tx_s_ff;
            reg          slp_m_ff, slp_s_ff;
            reg          bus_m_ff, bus_s_ff, bus_d_ff;
            reg  [1:0]   mode_ff;
            reg  [1:0]   nxt_mode;
            reg  [CW-1:0] slp_hi_ff, slp_lo_ff, bus_lo_ff, tx_lo_ff;
            reg          wake_req_ff;
            reg          tx_arm_ff;
            reg          drv_ff;
            reg          rx_val_ff;
            reg          rx_oe_ff;
            wire         pair_ok;
            wire         pair_hot;
            wire         tx_timeout;
            wire         rem_wake;
            wire         loc_norm;
            wire         go_sleep;

            // Pair-shared supply and temperature
            assign pair_ok  = supply_ok[i/2];
            assign pair_hot = overtemp[i/2];

            // Synchronisers; first stage feeds only the second
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    tx_m_ff  <= 1'b0;
                    tx_s_ff  <= 1'b0;
                    slp_m_ff <= 1'b0;
                    slp_s_ff <= 1'b0;
                    bus_m_ff <= 1'b1;
                    bus_s_ff <= 1'b1;
                    bus_d_ff <= 1'b1;
                end else begin
                    tx_m_ff  <= (tx_data_in[i] === 1'b1);
                    tx_s_ff  <= tx_m_ff;
                    slp_m_ff <= (sleep_ctrl_n[i] === 1'b1);
                    slp_s_ff <= slp_m_ff;
                    bus_m_ff <= bus_line_in[i];
                    bus_s_ff <= bus_m_ff;
                    bus_d_ff <= bus_s_ff;
                end
            end

            // Level-duration counters, saturating
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    slp_hi_ff <= {CW{1'b0}};
                    slp_lo_ff <= {CW{1'b0}};
                    bus_lo_ff <= {CW{1'b0}};
                    tx_lo_ff  <= {CW{1'b0}};
                end else begin
                    slp_hi_ff <= !slp_s_ff ? {CW{1'b0}} :
                                 (slp_hi_ff == CNT_MAX) ? slp_hi_ff : slp_hi_ff + CNT_ONE;
                    slp_lo_ff <= slp_s_ff ? {CW{1'b0}} :
                                 (slp_lo_ff == CNT_MAX) ? slp_lo_ff : slp_lo_ff + CNT_ONE;
                    bus_lo_ff <= bus_s_ff ? {CW{1'b0}} :
                                 (bus_lo_ff == CNT_MAX) ? bus_lo_ff : bus_lo_ff + CNT_ONE;
                    // Timer restarts at each falling edge, clears at rising
                    tx_lo_ff  <= tx_s_ff ? {CW{1'b0}} :
                                 (tx_lo_ff == CNT_MAX) ? tx_lo_ff : tx_lo_ff + CNT_ONE;
                end
            end

            // Filtered decisions
            assign go_sleep   = (slp_lo_ff > SLEEP_LIM);
            assign loc_norm   = (slp_hi_ff > NORM_LIM);
            assign rem_wake   = bus_s_ff && !bus_d_ff && (bus_lo_ff > WAKE_LIM);
            assign tx_timeout = (tx_lo_ff > TO_LIM);

            // Next mode
            always @* begin
                nxt_mode = mode_ff;
                if (!pair_ok) begin
                    nxt_mode = MODE_POR;
                end else begin
                    case (mode_ff)
                        MODE_POR: begin
                            nxt_mode = MODE_SLEEP;
                        end
                        MODE_SLEEP: begin
                            if (loc_norm) begin
                                nxt_mode = MODE_NORM;
                            end else if (rem_wake) begin
                                nxt_mode = MODE_STBY;
                            end
                        end
                        MODE_STBY: begin
                            if (loc_norm) begin
                                nxt_mode = MODE_NORM;
                            end
                        end
                        MODE_NORM: begin
                            if (go_sleep) begin
                                nxt_mode = MODE_SLEEP;
                            end
                        end
                        default: begin
                            nxt_mode = MODE_POR;
                        end
                    endcase
                end
            end

            // Mode register, one per channel
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    mode_ff <= MODE_POR;
                end else begin
                    mode_ff <= nxt_mode;
                end
            end

            // Wake request: set on remote wake, cleared at once by control high
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    wake_req_ff <= 1'b0;
                end else if (nxt_mode == MODE_STBY && mode_ff == MODE_SLEEP) begin
                    wake_req_ff <= 1'b1;
                end else if (mode_ff != MODE_STBY || slp_s_ff) begin
                    wake_req_ff <= 1'b0;
                end
            end

            // Driver armed only after transmit seen high in Normal
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    tx_arm_ff <= 1'b0;
                end else if (mode_ff != MODE_NORM) begin
                    tx_arm_ff <= 1'b0;
                end else if (tx_s_ff) begin
                    tx_arm_ff <= 1'b1;
                end
            end

            // Bus driver and receive pin, registered
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    drv_ff    <= 1'b0;
                    rx_val_ff <= 1'b1;
                    rx_oe_ff  <= 1'b0;
                end else begin
                    drv_ff <= (mode_ff == MODE_NORM) && tx_arm_ff && !tx_s_ff
                              && !tx_timeout
                              && !pair_hot;
                    // Receive pin follows the mode
                    case (mode_ff)
                        MODE_NORM: begin
                            rx_val_ff <= bus_s_ff;
                            rx_oe_ff  <= 1'b1;
                        end
                        MODE_STBY: begin
                            rx_val_ff <= !wake_req_ff;
                            rx_oe_ff  <= wake_req_ff && !slp_s_ff;
                        end
                        default: begin
                            rx_val_ff <= 1'b1;
                            rx_oe_ff  <= 1'b0;
                        end
                    endcase
                end
            end

            // Per-channel pins and mode reporting
            assign bus_line_oe[i]     = drv_ff;
            assign rx_data_out[i]     = rx_val_ff;
            assign rx_data_oe[i]      = rx_oe_ff;
            assign mode_all[2*i+1:2*i] = mode_ff;
            assign chg[i]             = (nxt_mode != mode_ff);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Mode-change event reporting through the two-entry buffer

    // Lowest pending channel goes first
    always @* begin
        sel     = 2'h0;
        sel_vld = 1'b0;
        if (pend_ff[0]) begin
            sel     = 2'h0;
            sel_vld = 1'b1;
        end else if (pend_ff[1]) begin
            sel     = 2'h1;
            sel_vld = 1'b1;
        end else if (pend_ff[2]) begin
            sel     = 2'h2;
            sel_vld = 1'b1;
        end else if (pend_ff[3]) begin
            sel     = 2'h3;
            sel_vld = 1'b1;
        end
    end

    // Push whenever a channel is pending and the buffer has room
    assign push = sel_vld & buf_ready;

    // Pending flags held while the buffer is full; new change wins over clear
    always @* begin
        nxt_pend = pend_ff;
        if (push) begin
            nxt_pend[sel] = 1'b0;
        end
        nxt_pend = nxt_pend | chg;
    end

    // Pending register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_ff <= 4'h0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // Event buffer
    qlt_buf #(
        .W (`QLT_EVT_W)
    ) u_buf (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (sel_vld),
        .in_ready  (buf_ready),
        .in_data   ({sel, mode_all[2*sel +: 2]}),
        .out_valid (evt_valid),
        .out_ready (evt_ready),
        .out_data  (evt_data)
    );

endmodule // qlt_top

// >>> dv/qlt_top_monitor.sv
// Checker for mode, driver and receive-pin behaviour of the transceiver block
`timescale 1ns/1ns
`include "qlt_regs.vh"
module qlt_top_monitor #(
    parameter GOTOSLEEP_CYC = 8, // Go-to-sleep filter, cycles
    parameter GOTONORM_CYC  = 8  // Go-to-normal filter, cycles
) (
    input wire       clk,          // Clock
    input wire       rstn,         // Reset, active low
    input wire [3:0] sleep_ctrl_n, // Control inputs
    input wire [3:0] bus_line_oe,  // Bus drive enables
    input wire [3:0] rx_data_out,  // Receive pins
    input wire [3:0] rx_data_oe,   // Receive enables
    input wire [1:0] supply_ok,    // Supply per pair
    input wire [1:0] overtemp,     // Overtemperature per pair
    input wire [1:0] mode_ch0,     // Channel 0 mode
    input wire [1:0] mode_ch1      // Channel 1 mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    reg [15:0] hi_cnt_ff;
    reg [15:0] lo_cnt_ff;
    //////////////////////////////////////////////////////////////////////////////
    // Run lengths of the channel 0 control level
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_cnt_ff <= 16'h0000;
            lo_cnt_ff <= 16'h0000;
        end else begin
            hi_cnt_ff <= (sleep_ctrl_n[0] === 1'b1) ? hi_cnt_ff + 16'h0001 : 16'h0000;
            lo_cnt_ff <= (sleep_ctrl_n[0] === 1'b1) ? 16'h0000 : lo_cnt_ff + 16'h0001;
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Named steps and properties
    sequence s_ctrl_hi4; sleep_ctrl_n[1] [*4]; endsequence
    sequence s_in_stby; mode_ch1 == `QLT_MODE_STBY; endsequence
    property p_wake_clear; s_ctrl_hi4 ##0 s_in_stby |-> !rx_data_oe[1]; endproperty
    property p_stby_rx; s_in_stby ##0 rx_data_oe[1] |-> !rx_data_out[1]; endproperty
    property p_sleep_cause;
        ($past(mode_ch0) == `QLT_MODE_NORM && mode_ch0 == `QLT_MODE_SLEEP)
            |-> lo_cnt_ff > GOTOSLEEP_CYC;
    endproperty
    property p_norm_cause;
        ($past(mode_ch0) != `QLT_MODE_NORM && mode_ch0 == `QLT_MODE_NORM)
            |-> hi_cnt_ff > GOTONORM_CYC;
    endproperty
    property p_por; !supply_ok[0] |=> mode_ch0 == `QLT_MODE_POR && mode_ch1 == `QLT_MODE_POR;
    endproperty
    property p_overtemp; $past(overtemp[0]) |-> bus_line_oe[1:0] == 2'h0; endproperty
    property p_drv_off;
        (mode_ch0 != `QLT_MODE_NORM && $past(mode_ch0) != `QLT_MODE_NORM) |-> !bus_line_oe[0];
    endproperty
    property p_rx_float;
        (mode_ch0 < `QLT_MODE_STBY && $past(mode_ch0) < `QLT_MODE_STBY) |-> !rx_data_oe[0];
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake flag kept");
    a_stby_rx: assert property (p_stby_rx) else $error("standby rx not low");
    a_sleep_cause: assert property (p_sleep_cause) else $error("early sleep");
    a_norm_cause: assert property (p_norm_cause) else $error("early normal");
    a_por: assert property (p_por) else $error("pair not in reset");
    a_overtemp: assert property (p_overtemp) else $error("driver on while hot");
    a_drv_off: assert property (p_drv_off) else $error("driver on outside normal");
    a_rx_float: assert property (p_rx_float) else $error("rx driven in sleep");
endmodule // qlt_top_monitor

bind qlt_top qlt_top_monitor #(.GOTOSLEEP_CYC(GOTOSLEEP_CYC), .GOTONORM_CYC(GOTONORM_CYC)) u_mon (
    .clk(clk), .rstn(rstn), .sleep_ctrl_n(sleep_ctrl_n), .bus_line_oe(bus_line_oe),
    .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .supply_ok(supply_ok),
    .overtemp(overtemp), .mode_ch0(mode_ch0), .mode_ch1(mode_ch1)
);

// >>> dv/qlt_ctrl_model.sv
// Controller-side model: drives transmit and control pins, takes mode events
`timescale 1ns/1ns
module qlt_ctrl_model (
    input  wire       clk,          // Clock
    input  wire       evt_valid,    // Event offered
    output wire       evt_ready,    // Event taken
    input  wire [3:0] evt_data,     // Event word
    output wire [3:0] tx_data_in,   // Transmit pins
    output wire [3:0] sleep_ctrl_n  // Control pins
);
    reg   [3:0] tx_ff;
    reg   [3:0] slp_ff;
    reg         stall_ff;
    logic [3:0] evq[$];
    initial begin
        tx_ff = 4'h0;
        slp_ff = 4'h0;
        stall_ff = 1'b0;
    end
    // Pin levels held until the bench asks for a change
    assign tx_data_in = tx_ff;
    assign sleep_ctrl_n = slp_ff;
    assign evt_ready = !stall_ff;
    // Setters, called only just after a falling edge
    task automatic set_tx(input int ch, input logic v);
        tx_ff[ch] = v;
    endtask
    task automatic set_slp(input int ch, input logic v);
        slp_ff[ch] = v;
    endtask
    task automatic set_stall(input logic v);
        stall_ff = v;
    endtask
    // Log each event taken
    always @(posedge clk) begin
        if (evt_valid && evt_ready) evq.push_back(evt_data);
    end
endmodule // qlt_ctrl_model

// >>> dv/tb_qlt_top.sv
// Bench for the four-channel transceiver mode control
`timescale 1ns/1ns
`include "qlt_regs.vh"
module tb_qlt_top;
    localparam SLP_C = 8;
    localparam NRM_C = 8;
    localparam DOM_C = 16;
    localparam TO_C  = 64;
    reg        clk;
    reg        rstn;
    reg  [3:0] ext_bus;
    reg  [1:0] supply_ok;
    reg  [1:0] overtemp;
    wire [3:0] tx_data_in;
    wire [3:0] sleep_ctrl_n;
    wire [3:0] bus_line_in;
    wire [3:0] bus_line_out;
    wire [3:0] bus_line_oe;
    wire [3:0] rx_data_out;
    wire [3:0] rx_data_oe;
    wire [1:0] mode_ch0;
    wire [1:0] mode_ch1;
    wire [1:0] mode_ch2;
    wire [1:0] mode_ch3;
    wire       evt_valid;
    wire       evt_ready;
    wire [3:0] evt_data;
    int        fails;
    int        n_tests;
    // Wired-AND bus with pull-up: far node or our driver pulls it low
    assign bus_line_in = ext_bus & ~(bus_line_oe & ~bus_line_out);
    qlt_top #(.GOTOSLEEP_CYC(SLP_C), .GOTONORM_CYC(NRM_C), .WAKE_DOM_CYC(DOM_C),
        .TX_TO_CYC(TO_C)) u_dut (
        .clk(clk), .rstn(rstn), .tx_data_in(tx_data_in), .sleep_ctrl_n(sleep_ctrl_n),
        .bus_line_in(bus_line_in), .bus_line_out(bus_line_out), .bus_line_oe(bus_line_oe),
        .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .supply_ok(supply_ok),
        .overtemp(overtemp), .mode_ch0(mode_ch0), .mode_ch1(mode_ch1), .mode_ch2(mode_ch2),
        .mode_ch3(mode_ch3), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data)
    );
    qlt_ctrl_model u_ctrl (
        .clk(clk), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data),
        .tx_data_in(tx_data_in), .sleep_ctrl_n(sleep_ctrl_n)
    );
    //////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [1:0] mode_of(input int ch);
        case (ch)
            0: mode_of = mode_ch0;
            1: mode_of = mode_ch1;
            2: mode_of = mode_ch2;
            default: mode_of = mode_ch3;
        endcase
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk_mode(input int ch, input logic [1:0] exp);
        n_tests++;
        if (mode_of(ch) !== exp) begin
            fails++;
            $display("mismatch at %0t: ch%0d mode %h not %h", $time, ch, mode_of(ch), exp);
        end
    endtask
    task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: pins %h not %h", $time, got, exp);
        end
    endtask
    task automatic wait_mode(input int ch, input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && mode_of(ch) !== m; i++) @(negedge clk);
        chk_mode(ch, m);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_por;
        cyc(4);
        for (int c = 0; c < 4; c++) chk_mode(c, `QLT_MODE_POR);
        chk_flag(rx_data_oe | bus_line_oe, 4'h0);
        supply_ok = 2'h3;
        for (int c = 0; c < 4; c++) wait_mode(c, `QLT_MODE_SLEEP, 6);
        chk_flag(rx_data_oe, 4'h0);
    endtask
    task automatic t_local;
        u_ctrl.set_tx(0, 1'bz);
        u_ctrl.set_slp(0, 1'b1);
        cyc(NRM_C);
        u_ctrl.set_slp(0, 1'b0);
        cyc(20);
        chk_mode(0, `QLT_MODE_SLEEP);
        u_ctrl.set_slp(0, 1'b1);
        wait_mode(0, `QLT_MODE_NORM, NRM_C + 12);
        chk_mode(1, `QLT_MODE_SLEEP);
        cyc(10);
        chk_flag(rx_data_oe & rx_data_out & 4'h1, 4'h1);
        chk_flag(bus_line_oe, 4'h0);
    endtask
    task automatic t_tx;
        u_ctrl.set_tx(0, 1'b1);
        cyc(5);
        chk_flag(bus_line_oe, 4'h0);
        chk_flag(bus_line_out, 4'h0);
        u_ctrl.set_tx(0, 1'b0);
        cyc(4);
        chk_flag(bus_line_oe, 4'h1);
        cyc(4);
        chk_flag(rx_data_out & 4'h1, 4'h0);
        overtemp = 2'h1;
        cyc(2);
        chk_flag(bus_line_oe, 4'h0);
        overtemp = 2'h0;
        cyc(2);
        chk_flag(bus_line_oe, 4'h1);
        cyc(TO_C);
        chk_flag(bus_line_oe, 4'h0);
        u_ctrl.set_tx(0, 1'b1);
        cyc(4);
        u_ctrl.set_tx(0, 1'b0);
        cyc(4);
        chk_flag(bus_line_oe, 4'h1);
        u_ctrl.set_tx(0, 1'b1);
        cyc(4);
    endtask
    task automatic t_sleep;
        u_ctrl.set_slp(0, 1'bz);
        cyc(SLP_C);
        chk_mode(0, `QLT_MODE_NORM);
        wait_mode(0, `QLT_MODE_SLEEP, 16);
        cyc(2);
        chk_flag(rx_data_oe & 4'h1, 4'h0);
    endtask
    task automatic t_remote;
        ext_bus[1] = 1'b0;
        cyc(DOM_C);
        ext_bus[1] = 1'b1;
        cyc(10);
        chk_mode(1, `QLT_MODE_SLEEP);
        ext_bus[1] = 1'b0;
        cyc(DOM_C + 14);
        chk_mode(1, `QLT_MODE_SLEEP);
        ext_bus[1] = 1'b1;
        wait_mode(1, `QLT_MODE_STBY, 6);
        cyc(2);
        chk_flag(rx_data_oe & ~rx_data_out & 4'h2, 4'h2);
        chk_flag(bus_line_oe & 4'h2, 4'h0);
        u_ctrl.set_slp(1, 1'b1);
        cyc(4);
        chk_flag(rx_data_oe & 4'h2, 4'h0);
        chk_mode(1, `QLT_MODE_STBY);
        wait_mode(1, `QLT_MODE_NORM, NRM_C + 8);
    endtask
    task automatic t_events;
        cyc(4);
        u_ctrl.evq.delete();
        u_ctrl.set_stall(1'b1);
        u_ctrl.set_slp(2, 1'b1);
        u_ctrl.set_slp(3, 1'b1);
        wait_mode(3, `QLT_MODE_NORM, NRM_C + 12);
        u_ctrl.set_slp(2, 1'b0);
        wait_mode(2, `QLT_MODE_SLEEP, SLP_C + 12);
        cyc(3);
        chk_flag({evt_valid, 3'h0}, 4'h8);
        chk_flag(evt_data, 4'hB);
        u_ctrl.set_stall(1'b0);
        cyc(6);
        chk_flag(4'(u_ctrl.evq.size()), 4'h3);
        chk_flag(u_ctrl.evq[0], 4'hB);
        chk_flag(u_ctrl.evq[1], 4'hF);
        chk_flag(u_ctrl.evq[2], 4'h9);
        supply_ok = 2'h1;
        cyc(3);
        chk_mode(2, `QLT_MODE_POR);
        chk_mode(3, `QLT_MODE_POR);
        chk_mode(0, `QLT_MODE_SLEEP);
        chk_mode(1, `QLT_MODE_NORM);
        supply_ok = 2'h3;
        wait_mode(3, `QLT_MODE_SLEEP, 6);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // Verdict, clock, sequence and watchdog
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        ext_bus = 4'hF;
        supply_ok = 2'h0;
        overtemp = 2'h0;
        fails = 0;
        n_tests = 0;
        cyc(20);
        rstn = 1'b1;
        t_por;
        t_local;
        t_tx;
        t_sleep;
        t_remote;
        t_events;
        results;
    end
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        $display("mismatch at %0t: run too long", $time);
        results;
    end
endmodule // tb_qlt_top
